// >>> rtl/sbcmc_pkg.sv
// package: constants and types of the operating-mode controller with its serial slave
package sbcmc_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned T_RST_SHORT_NS  = 3_600_000;
  localparam int unsigned T_RST_LONG_NS   = 20_000_000;
  localparam int unsigned RST_SHORT_CYC   = (T_RST_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_LONG_CYC    = (T_RST_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FRAME_BITS      = 16;
  localparam int unsigned BITCNT_W        = 5;

  // register addresses
  localparam logic [2:0] ADDR_WDT_STATUS  = 3'h0;
  localparam logic [2:0] ADDR_MODE_SELECT = 3'h1;
  localparam logic [2:0] ADDR_IRQ_ENABLE  = 3'h2;
  localparam logic [2:0] ADDR_IRQ_FLAG    = 3'h3;

  // watchdog/status fields
  localparam int unsigned WDS_WMC_BIT     = 11;
  localparam int unsigned WDS_NWP_LSB     = 8;
  localparam int unsigned WDS_WOS_BIT     = 7;
  localparam int unsigned WDS_RSV1_BIT    = 5;
  localparam logic [2:0]  NWP_RESET       = 3'h4;

  // mode select fields
  localparam int unsigned MS_MC_LSB       = 10;
  localparam int unsigned MS_LIN_STANDBY_CTRL_BIT    = 9;
  localparam int unsigned MS_FALLBACK_BIT = 8;
  localparam int unsigned MS_RSTLONG_BIT  = 7;
  localparam logic [1:0]  MC_STANDBY      = 2'h0;
  localparam logic [1:0]  MC_SLEEP        = 2'h1;

  // interrupt enable / flag fields
  localparam int unsigned IRQ_LIN_WAKE    = 0;
  localparam int unsigned IRQ_LOCAL_WAKE  = 1;
  localparam int unsigned IRQ_POWER_ON    = 2;
  localparam logic [11:0] IRQ_ENABLE_RST  = 12'h003;

  typedef struct packed {
    logic [2:0]  reg_addr_bits;
    logic        read_only_flag;
    logic [11:0] data;
  } sbcmc_frame_t;

  typedef enum logic [4:0] {
    SBCMC_OFF      = 5'b0_0001,
    SBCMC_STANDBY  = 5'b0_0010,
    SBCMC_NORMAL   = 5'b0_0100,
    SBCMC_SLEEP    = 5'b0_1000,
    SBCMC_OVERTEMP = 5'b1_0000
  } sbcmc_mode_t;

  typedef enum logic [1:0] {
    LIN_OFF      = 2'h0,
    LIN_LOWPOWER = 2'h1,
    LIN_ACTIVE   = 2'h2,
    LIN_HIGHZ    = 2'h3
  } sbcmc_lin_t;

  typedef enum logic [1:0] {
    WDT_OFF     = 2'h0,
    WDT_TIMEOUT = 2'h1,
    WDT_WINDOW  = 2'h2
  } sbcmc_wdt_t;
endpackage : sbcmc_pkg

// >>> rtl/sbcmc_top.sv
// operating-mode controller of a system basis chip with its 16-bit serial register slave
`timescale 1ns/1ps
`default_nettype none
module sbcmc_top
  import sbcmc_pkg::*;
#(
  parameter int unsigned P_RST_SHORT_CYC = sbcmc_pkg::RST_SHORT_CYC,
  parameter int unsigned P_RST_LONG_CYC  = sbcmc_pkg::RST_LONG_CYC
) (
  // core clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_resetn,
  // serial slave pins
  input  wire logic                 i_spi_clk,
  input  wire logic                 i_chip_select_n,
  input  wire logic                 i_spi_sdi,
  output logic                      o_spi_sdo,
  output logic                      o_spi_sdo_oe,
  // supply, temperature, wake and watchdog-disable indications
  input  wire logic                 i_bat_poff,
  input  wire logic                 i_bat_pon,
  input  wire logic                 i_otp_act,
  input  wire logic                 i_otp_rel,
  input  wire logic                 i_wake_lin,
  input  wire logic                 i_wake_local,
  input  wire logic                 i_watchdog_disable_pin,
  // open-drain reset pin
  input  wire logic                 i_reset_pin_n,
  output logic                      o_reset_pin_n_out,
  output logic                      o_reset_pin_n_oe,
  // controlled functions
  output logic                      o_mcu_regulator_out,
  output sbcmc_pkg::sbcmc_lin_t     o_lin_state,
  output sbcmc_pkg::sbcmc_wdt_t     o_wdt_state,
  output sbcmc_pkg::sbcmc_mode_t    o_mode,
  output logic                      o_irq_pin_n,
  output logic                      o_fallback_n
);
  import sbcmc_pkg::*;

  localparam int unsigned RC_W = $clog2(P_RST_LONG_CYC + 1);

  if (P_RST_SHORT_CYC < 1 || P_RST_LONG_CYC < P_RST_SHORT_CYC) begin : g_chk
    $error("reset widths must be at least one cycle and long not below short");
  end

  // ---------------- link domain (serial clock) ----------------
  logic [BITCNT_W-1:0] bit_cnt;
  logic [15:0]         rx_shift;
  logic [15:0]         tx_shift;
  sbcmc_frame_t        rx_frame;
  logic                rx_toggle;
  logic [15:0]         rd_word;

  // bit counter and input shifter, cleared while chip select is high
  always_ff @(negedge i_spi_clk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      bit_cnt  <= '0;
      rx_shift <= '0;
    end else begin
      rx_shift <= {rx_shift[14:0], i_spi_sdi};
      if (bit_cnt != BITCNT_W'(FRAME_BITS))
        bit_cnt <= bit_cnt + BITCNT_W'(1);
    end
  end

  // the completed frame is held and announced by a toggle; extra bits are ignored
  always_ff @(negedge i_spi_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_frame  <= '0;
      rx_toggle <= 1'b0;
    end else if (!i_chip_select_n && bit_cnt == BITCNT_W'(FRAME_BITS - 1)) begin
      rx_frame  <= {rx_shift[14:0], i_spi_sdi};
      rx_toggle <= ~rx_toggle;
    end
  end

  // rd_word is reloaded every core cycle from the register named by the last applied frame; the first rise of a frame freezes it in tx_shift
  always_ff @(posedge i_spi_clk or posedge i_chip_select_n) begin
    if (i_chip_select_n)
      tx_shift <= '0;
    else if (bit_cnt == '0)
      // bit 15 must still stand at the first fall, so the whole word loads and the next rise shifts
      tx_shift <= rd_word;
    else
      tx_shift <= {tx_shift[14:0], 1'b0};
  end

  assign o_spi_sdo    = (bit_cnt == '0) ? rd_word[15] : tx_shift[15];
  assign o_spi_sdo_oe = ~i_chip_select_n;

  // ---------------- core domain ----------------
  logic [2:0] tog_sync;
  logic [1:0] cs_sync;
  logic [1:0] poff_s, pon_s, ota_s, otr_s, wl_s, wk_s, wdp_s, rpin_s;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tog_sync <= '0;
      cs_sync  <= 2'h3;
      poff_s   <= '0;
      pon_s    <= '0;
      ota_s    <= '0;
      otr_s    <= '0;
      wl_s     <= '0;
      wk_s     <= '0;
      wdp_s    <= '0;
      rpin_s   <= 2'h3;
    end else begin
      tog_sync <= {tog_sync[1:0], rx_toggle};
      cs_sync  <= {cs_sync[0], i_chip_select_n};
      poff_s   <= {poff_s[0], i_bat_poff};
      pon_s    <= {pon_s[0], i_bat_pon};
      ota_s    <= {ota_s[0], i_otp_act};
      otr_s    <= {otr_s[0], i_otp_rel};
      wl_s     <= {wl_s[0], i_wake_lin};
      wk_s     <= {wk_s[0], i_wake_local};
      wdp_s    <= {wdp_s[0], i_watchdog_disable_pin};
      rpin_s   <= {rpin_s[0], i_reset_pin_n};
    end
  end

  // a frame waits here until chip select is seen high again
  logic frame_pend;
  logic apply;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn)
      frame_pend <= 1'b0;
    else if (tog_sync[2] != tog_sync[1])
      frame_pend <= 1'b1;
    else if (cs_sync[1])
      frame_pend <= 1'b0;
  end
  assign apply = frame_pend && cs_sync[1] && (tog_sync[2] == tog_sync[1]);

  sbcmc_frame_t fr;
  logic         wr_en;
  assign fr    = rx_frame;
  assign wr_en = apply && !fr.read_only_flag;

  // registers
  sbcmc_mode_t mode;
  logic        wdt_mode_ctrl;
  logic [2:0]  nwp;
  logic [1:0]  mode_select_bits;
  logic        lin_standby_ctrl;
  logic        fallback_ctrl_bit;
  logic        rst_long_sel;
  logic [11:0] irq_enable;
  logic [11:0] irq_flag;
  logic [2:0]  last_addr;
  logic        last_ro;

  logic wake_ev, wake_ok, sleep_ok, mc_wr, ext_rst, rst_busy;
  logic [RC_W-1:0] rst_cnt;
  logic [1:0]      mc_new;

  assign mc_wr   = wr_en && fr.reg_addr_bits == ADDR_MODE_SELECT;
  assign mc_new  = fr.data[MS_MC_LSB +: 2];
  assign wake_ev = (wl_s[1] && irq_enable[IRQ_LIN_WAKE]) || (wk_s[1] && irq_enable[IRQ_LOCAL_WAKE]);
  assign wake_ok = irq_enable[IRQ_LIN_WAKE] || irq_enable[IRQ_LOCAL_WAKE];
  assign sleep_ok = o_irq_pin_n && !irq_flag[IRQ_LIN_WAKE] && !irq_flag[IRQ_LOCAL_WAKE] && wake_ok;
  assign rst_busy = rst_cnt != '0;
  // the pin is only read while we do not pull it ourselves; after we let go it reads
  // back low for two more cycles while the synchroniser catches up, so that is masked
  logic [1:0] oe_hist;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn)
      oe_hist <= 2'h3;
    else
      oe_hist <= {oe_hist[0], o_reset_pin_n_oe};
  end
  assign ext_rst  = !rpin_s[1] && !o_reset_pin_n_oe && (oe_hist == 2'h0);

  // reset pulse width selected by the mode register; the start strobe covers the first
  // cycle, so the counter holds the rest and the pin never lets go between modes
  logic [RC_W-1:0] rst_cfg;
  assign rst_cfg = rst_long_sel ? RC_W'(P_RST_LONG_CYC - 1) : RC_W'(P_RST_SHORT_CYC - 1);

  // operating-mode state machine
  logic start_rst;
  logic start_short;
  logic rst_drive;
  assign rst_drive = rst_busy || start_rst || start_short;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode        <= SBCMC_OFF;
      start_rst   <= 1'b0;
      start_short <= 1'b0;
    end else begin
      start_rst   <= 1'b0;
      start_short <= 1'b0;
      if (poff_s[1]) begin
        mode <= SBCMC_OFF;
      end else begin
        case (mode)
          SBCMC_OFF: begin
            if (pon_s[1]) begin
              mode      <= SBCMC_STANDBY;
              start_rst <= 1'b1;
            end
          end
          SBCMC_STANDBY, SBCMC_NORMAL: begin
            if (ota_s[1]) begin
              mode <= SBCMC_OVERTEMP;
            end else if (mc_wr && mc_new == MC_SLEEP) begin
              if (sleep_ok) begin
                mode <= SBCMC_SLEEP;
              end else begin
                mode        <= SBCMC_STANDBY;
                start_short <= 1'b1;
              end
            end else if (mode == SBCMC_STANDBY && mc_wr && mc_new[1]) begin
              mode <= SBCMC_NORMAL;
            end else if (mode == SBCMC_NORMAL && ((mc_wr && mc_new == MC_STANDBY) || ext_rst || rst_busy)) begin
              mode <= SBCMC_STANDBY;
            end
          end
          SBCMC_SLEEP: begin
            if (wake_ev) begin
              mode      <= SBCMC_STANDBY;
              start_rst <= 1'b1;
            end
          end
          SBCMC_OVERTEMP: begin
            if (otr_s[1]) begin
              mode      <= SBCMC_STANDBY;
              start_rst <= 1'b1;
            end
          end
          default: begin
            mode <= SBCMC_OFF;
          end
        endcase
      end
    end
  end

  // system reset pulse counter
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn)
      rst_cnt <= '0;
    else if (start_short)
      rst_cnt <= RC_W'(P_RST_SHORT_CYC - 1);
    else if (start_rst)
      rst_cnt <= rst_cfg;
    else if (rst_busy)
      rst_cnt <= rst_cnt - RC_W'(1);
  end

  // watchdog/status register
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdt_mode_ctrl <= 1'b0;
      nwp <= NWP_RESET;
    end else if (wr_en && fr.reg_addr_bits == ADDR_WDT_STATUS) begin
      wdt_mode_ctrl <= fr.data[WDS_WMC_BIT];
      nwp <= fr.data[WDS_NWP_LSB +: 3];
    end
  end

  // mode select register; hardware updates win over a host write in the same cycle
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_select_bits  <= MC_STANDBY;
      lin_standby_ctrl  <= 1'b0;
      fallback_ctrl_bit <= 1'b0;
      rst_long_sel      <= 1'b0;
    end else begin
      if (mc_wr) begin
        mode_select_bits  <= mc_new;
        lin_standby_ctrl  <= fr.data[MS_LIN_STANDBY_CTRL_BIT];
        fallback_ctrl_bit <= fr.data[MS_FALLBACK_BIT];
        rst_long_sel      <= fr.data[MS_RSTLONG_BIT];
      end
      if ((mode == SBCMC_SLEEP && wake_ev) || start_short_req())
        mode_select_bits <= MC_STANDBY;
      if (mode != SBCMC_OVERTEMP && ota_s[1] && (mode == SBCMC_STANDBY || mode == SBCMC_NORMAL))
        fallback_ctrl_bit <= 1'b1;
    end
  end

  // a refused sleep request also falls back to standby selection
  function automatic logic start_short_req();
    start_short_req = (mode == SBCMC_STANDBY || mode == SBCMC_NORMAL) && !ota_s[1]
                      && mc_wr && mc_new == MC_SLEEP && !sleep_ok;
  endfunction : start_short_req

  // interrupt enable and sticky flags; flags clear by writing one, a new event wins
  logic [11:0] flag_set;
  always_comb begin
    flag_set                 = '0;
    flag_set[IRQ_LIN_WAKE]   = wl_s[1] && mode == SBCMC_SLEEP;
    flag_set[IRQ_LOCAL_WAKE] = wk_s[1] && mode == SBCMC_SLEEP;
    flag_set[IRQ_POWER_ON]   = mode == SBCMC_OFF && pon_s[1];
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_enable <= IRQ_ENABLE_RST;
      irq_flag   <= '0;
    end else begin
      if (wr_en && fr.reg_addr_bits == ADDR_IRQ_ENABLE)
        irq_enable <= fr.data;
      if (wr_en && fr.reg_addr_bits == ADDR_IRQ_FLAG)
        irq_flag <= (irq_flag & ~fr.data) | flag_set;
      else
        irq_flag <= irq_flag | flag_set;
    end
  end

  // readback word for the register addressed by the last frame
  logic [11:0] rd_body;
  always_comb begin
    rd_body = '0;
    case (last_addr)
      ADDR_WDT_STATUS: begin
        rd_body[WDS_WMC_BIT]        = wdt_mode_ctrl;
        rd_body[WDS_NWP_LSB +: 3]   = nwp;
        rd_body[WDS_WOS_BIT]        = wdp_s[1];
        rd_body[WDS_RSV1_BIT]       = 1'b1;
      end
      ADDR_MODE_SELECT: begin
        rd_body[MS_MC_LSB +: 2]     = mode_select_bits;
        rd_body[MS_LIN_STANDBY_CTRL_BIT]       = lin_standby_ctrl;
        rd_body[MS_FALLBACK_BIT]    = fallback_ctrl_bit;
        rd_body[MS_RSTLONG_BIT]     = rst_long_sel;
      end
      ADDR_IRQ_ENABLE: rd_body = irq_enable;
      ADDR_IRQ_FLAG:   rd_body = irq_flag;
      default:         rd_body = '0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      last_addr <= ADDR_WDT_STATUS;
      last_ro   <= 1'b0;
      rd_word   <= '0;
    end else begin
      if (apply) begin
        last_addr <= fr.reg_addr_bits;
        last_ro   <= fr.read_only_flag;
      end
      rd_word <= {last_addr, last_ro, rd_body};
    end
  end

  // registered outputs
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mcu_regulator_out <= 1'b0;
      o_lin_state         <= LIN_HIGHZ;
      o_wdt_state         <= WDT_OFF;
      o_mode              <= SBCMC_OFF;
      o_reset_pin_n_out   <= 1'b0;
      o_reset_pin_n_oe    <= 1'b1;
      o_irq_pin_n         <= 1'b1;
      o_fallback_n        <= 1'b1;
    end else begin
      o_mode            <= mode;
      o_reset_pin_n_out <= 1'b0;
      o_irq_pin_n       <= ~|(irq_flag & irq_enable);
      o_fallback_n      <= ~fallback_ctrl_bit;
      case (mode)
        SBCMC_STANDBY: begin
          o_mcu_regulator_out <= 1'b1;
          o_lin_state         <= lin_standby_ctrl ? LIN_LOWPOWER : LIN_OFF;
          o_wdt_state         <= (wdp_s[1] || wdt_mode_ctrl) ? WDT_OFF : WDT_TIMEOUT;
          o_reset_pin_n_oe    <= rst_drive;
        end
        SBCMC_NORMAL: begin
          o_mcu_regulator_out <= 1'b1;
          o_lin_state         <= lin_standby_ctrl ? LIN_LOWPOWER : LIN_ACTIVE;
          o_wdt_state         <= wdp_s[1] ? WDT_OFF : (wdt_mode_ctrl ? WDT_TIMEOUT : WDT_WINDOW);
          o_reset_pin_n_oe    <= rst_drive;
        end
        SBCMC_SLEEP: begin
          o_mcu_regulator_out <= 1'b0;
          o_lin_state         <= lin_standby_ctrl ? LIN_LOWPOWER : LIN_OFF;
          o_wdt_state         <= WDT_OFF;
          o_reset_pin_n_oe    <= 1'b1;
        end
        SBCMC_OVERTEMP: begin
          o_mcu_regulator_out <= 1'b0;
          o_lin_state         <= LIN_HIGHZ;
          o_wdt_state         <= WDT_OFF;
          o_reset_pin_n_oe    <= 1'b1;
        end
        default: begin
          o_mcu_regulator_out <= 1'b0;
          o_lin_state         <= LIN_HIGHZ;
          o_wdt_state         <= WDT_OFF;
          o_reset_pin_n_oe    <= 1'b1;
        end
      endcase
    end
  end
endmodule : sbcmc_top
`default_nettype wire

// >>> testbench/sbcmc_properties.sv
// checker: concurrent properties at the ports of the mode controller
`timescale 1ns/1ps
`default_nettype none
module sbcmc_properties #(
  parameter int unsigned P_RST_SHORT_CYC = sbcmc_pkg::RST_SHORT_CYC,
  parameter int unsigned P_RST_LONG_CYC  = sbcmc_pkg::RST_LONG_CYC
) (
  // clock and reset
  input wire logic                   i_core_clk,
  input wire logic                   i_resetn,
  // watched inputs
  input wire logic                   i_chip_select_n,
  input wire logic                   i_bat_poff,
  input wire logic                   i_bat_pon,
  input wire logic                   i_otp_act,
  // watched outputs
  input wire logic                   o_spi_sdo_oe,
  input wire logic                   o_reset_pin_n_oe,
  input wire logic                   o_mcu_regulator_out,
  input wire sbcmc_pkg::sbcmc_lin_t  o_lin_state,
  input wire sbcmc_pkg::sbcmc_wdt_t  o_wdt_state,
  input wire sbcmc_pkg::sbcmc_mode_t o_mode,
  input wire logic                   o_fallback_n
);
  import sbcmc_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // length of the current reset pull, so a pulse that ends early is caught
  int unsigned hi_cnt;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) hi_cnt <= 0;
    else hi_cnt <= o_reset_pin_n_oe ? hi_cnt + 1 : 0;
  end
  off_poff_a: assert property (i_bat_poff [*6] |-> o_mode == SBCMC_OFF)
    else $error("mode not off under low battery");
  off_outs_a: assert property (o_mode == SBCMC_OFF && $past(o_mode) == SBCMC_OFF
    |-> !o_mcu_regulator_out && o_lin_state == LIN_HIGHZ) else $error("off outputs wrong");
  pon_exit_a: assert property (o_mode == SBCMC_OFF && i_bat_pon && !i_bat_poff
    |-> ##[1:8] (o_mode == SBCMC_STANDBY || i_bat_poff)) else $error("no standby after power on");
  rst_width_a: assert property ($fell(o_reset_pin_n_oe) |-> hi_cnt >= P_RST_SHORT_CYC)
    else $error("reset pulse too short");
  stby_outs_a: assert property (o_mode == SBCMC_STANDBY && $past(o_mode) == SBCMC_STANDBY
    |-> o_mcu_regulator_out && (o_lin_state == LIN_OFF || o_lin_state == LIN_LOWPOWER)
    && o_wdt_state != WDT_WINDOW) else $error("standby outputs wrong");
  norm_lin_a: assert property (o_mode == SBCMC_NORMAL && $past(o_mode) == SBCMC_NORMAL
    |-> o_lin_state inside {LIN_ACTIVE, LIN_LOWPOWER}) else $error("normal lin state wrong");
  sleep_outs_a: assert property (o_mode == SBCMC_SLEEP && $past(o_mode) == SBCMC_SLEEP
    |-> !o_mcu_regulator_out && o_wdt_state == WDT_OFF && o_reset_pin_n_oe) else $error("sleep outputs wrong");
  otp_entry_a: assert property ((o_mode == SBCMC_NORMAL || o_mode == SBCMC_STANDBY)
    && i_otp_act && !i_bat_poff |-> ##[1:6] o_mode == SBCMC_OVERTEMP) else $error("no overtemp entry");
  otp_outs_a: assert property (o_mode == SBCMC_OVERTEMP && $past(o_mode, 2) == SBCMC_OVERTEMP
    |-> !o_mcu_regulator_out && o_lin_state == LIN_HIGHZ && o_reset_pin_n_oe && !o_fallback_n)
    else $error("overtemp outputs wrong");
  sdo_float_a: assert property (o_spi_sdo_oe == !i_chip_select_n)
    else $error("data output enable not tied to select");
endmodule : sbcmc_properties
`default_nettype wire

// >>> testbench/sbcmc_host.sv
// partner model: host microcontroller acting as serial master
`timescale 1ns/1ps
`default_nettype none
module sbcmc_host (
  // serial pins
  output var logic o_sck,
  output var logic o_cs_n,
  output var logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // one whole frame, header first; the clock runs only inside it
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    #7 o_cs_n = 1'b0;
    o_sdi = tx[15];
    for (i = 15; i >= 0; i--) begin
      #40 o_sck = 1'b1;
      if (i < 15) o_sdi = tx[i];
      #40 rx[i] = i_sdo_oe ? i_sdo : 1'bx;
      o_sck = 1'b0;
    end
    #40 o_cs_n = 1'b1;
    // released line shows the inverse so a stale bit is never trusted
    o_sdi = ~o_sdi;
    #360;
  endtask : xfer
endmodule : sbcmc_host
`default_nettype wire

// >>> testbench/test_sbcmc_top.sv
// testbench: mode controller driven by a host model, scenario by scenario
`timescale 1ns/1ps
`default_nettype none
module test_sbcmc_top;
  import sbcmc_pkg::*;
  // shortened reset pulses keep the run brief
  localparam int unsigned SHORT = 20;
  localparam int unsigned LONG  = 40;
  logic        clk, reset_pin_n, poff, pon, oact, orel, wlin, wloc, wdis, ext_rst_n;
  logic        sck, cs_n, sdi, sdo, sdo_oe, rst_out, rst_oe, reg_on, irq_n, fb_n;
  logic [15:0] rx;
  sbcmc_lin_t  lin;
  sbcmc_wdt_t  wdt;
  sbcmc_mode_t mode;
  wire logic   rst_wire;
  int          error_cnt = 0;
  int          n_compared = 0;
  time         t_rise;
  // open-drain reset wire with pull-up
  assign rst_wire = rst_oe ? rst_out : ext_rst_n;
  sbcmc_top #(.P_RST_SHORT_CYC(SHORT), .P_RST_LONG_CYC(LONG)) dut (
    .i_core_clk(clk), .i_resetn(reset_pin_n), .i_spi_clk(sck), .i_chip_select_n(cs_n), .i_spi_sdi(sdi),
    .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe), .i_bat_poff(poff), .i_bat_pon(pon), .i_otp_act(oact),
    .i_otp_rel(orel), .i_wake_lin(wlin), .i_wake_local(wloc), .i_watchdog_disable_pin(wdis),
    .i_reset_pin_n(rst_wire), .o_reset_pin_n_out(rst_out), .o_reset_pin_n_oe(rst_oe),
    .o_mcu_regulator_out(reg_on), .o_lin_state(lin), .o_wdt_state(wdt), .o_mode(mode),
    .o_irq_pin_n(irq_n), .o_fallback_n(fb_n));
  sbcmc_host host (.o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));
  // start of the current reset pull, so a pulse already running is measured whole
  always @(posedge rst_oe) t_rise = $time;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic outs(input logic r, input logic o, input sbcmc_wdt_t w, input sbcmc_lin_t l, input string s);
    chk({10'h000, reg_on, rst_oe, wdt, lin}, {10'h000, r, o, w, l}, s);
  endtask : outs
  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    host.xfer({a, 1'b0, d}, rx);
    cyc(8);
  endtask : wr
  // the answer carries the register named by the frame before
  task automatic rd(input logic [2:0] a, input logic [11:0] exp);
    host.xfer({a, 1'b1, 12'h000}, rx);
    host.xfer({a, 1'b1, 12'h000}, rx);
    chk(rx, {a, 1'b1, exp}, "readback");
  endtask : rd
  task automatic wmode(input sbcmc_mode_t m);
    for (int k = 0; k < 300 && mode !== m; k++) cyc(1);
    cyc(2);
    chk(16'(mode), 16'(m), "mode");
  endtask : wmode
  task automatic pulse_len(output int n);
    for (int k = 0; k < 40 && rst_oe !== 1'b1; k++) cyc(1);
    for (int k = 0; k < 200 && rst_oe === 1'b1; k++) cyc(1);
    n = int'(($time - t_rise) / CLK_PERIOD_NS);
  endtask : pulse_len
  task automatic t_power_up();
    wmode(SBCMC_STANDBY);
    outs(1'b1, 1'b1, WDT_TIMEOUT, LIN_OFF, "power up");
    rd(ADDR_WDT_STATUS, 12'h420);
    rd(ADDR_MODE_SELECT, 12'h000);
    rd(ADDR_IRQ_ENABLE, 12'h003);
    rd(ADDR_IRQ_FLAG, 12'h004);
    rd(3'h5, 12'h000);
  endtask : t_power_up
  task automatic t_ro();
    host.xfer({ADDR_MODE_SELECT, 1'b1, 12'h800}, rx);
    cyc(8);
    chk(16'(mode), 16'(SBCMC_STANDBY), "read only write");
    rd(ADDR_MODE_SELECT, 12'h000);
  endtask : t_ro
  task automatic t_normal();
    for (int m = 2; m < 4; m++) begin
      wr(ADDR_MODE_SELECT, {m[1:0], 10'h000});
      wmode(SBCMC_NORMAL);
      outs(1'b1, 1'b0, WDT_WINDOW, LIN_ACTIVE, "normal");
      wr(ADDR_MODE_SELECT, {m[1:0], 10'h200});
      outs(1'b1, 1'b0, WDT_WINDOW, LIN_LOWPOWER, "normal lp");
      wr(ADDR_MODE_SELECT, 12'h200);
      wmode(SBCMC_STANDBY);
    end
    wr(ADDR_WDT_STATUS, 12'hC00);
    outs(1'b1, 1'b0, WDT_OFF, LIN_LOWPOWER, "standby wmc");
    wr(ADDR_MODE_SELECT, 12'hA00);
    wmode(SBCMC_NORMAL);
    outs(1'b1, 1'b0, WDT_TIMEOUT, LIN_LOWPOWER, "normal wmc");
    wdis = 1'b1;
    cyc(6);
    chk(16'(wdt), 16'(WDT_OFF), "watchdog pin");
    ext_rst_n = 1'b0;
    cyc(4);
    ext_rst_n = 1'b1;
    wmode(SBCMC_STANDBY);
    wdis = 1'b0;
    wr(ADDR_WDT_STATUS, 12'h400);
  endtask : t_normal
  task automatic t_sleep();
    int n;
    wr(ADDR_IRQ_ENABLE, 12'h000);
    host.xfer({ADDR_MODE_SELECT, 1'b0, 12'h600}, rx);
    pulse_len(n);
    chk({15'h0000, n == SHORT}, 16'h0001, "refused sleep pulse");
    chk(16'(mode), 16'(SBCMC_STANDBY), "refused sleep");
    rd(ADDR_MODE_SELECT, 12'h200);
    wr(ADDR_IRQ_ENABLE, 12'h003);
    wr(ADDR_MODE_SELECT, 12'h600);
    wmode(SBCMC_SLEEP);
    outs(1'b0, 1'b1, WDT_OFF, LIN_LOWPOWER, "sleep");
    wlin = 1'b1;
    pulse_len(n);
    wlin = 1'b0;
    chk({15'h0000, n >= SHORT}, 16'h0001, "wake pulse");
    outs(1'b1, 1'b0, WDT_TIMEOUT, LIN_LOWPOWER, "wake");
    chk({15'h0000, irq_n}, 16'h0000, "wake irq pin");
    rd(ADDR_MODE_SELECT, 12'h200);
    wr(ADDR_IRQ_FLAG, 12'h003);
    chk({15'h0000, irq_n}, 16'h0001, "irq pin released");
  endtask : t_sleep
  task automatic t_otp();
    int n;
    wr(ADDR_MODE_SELECT, 12'h080);
    oact = 1'b1;
    wmode(SBCMC_OVERTEMP);
    cyc(1);
    outs(1'b0, 1'b1, WDT_OFF, LIN_HIGHZ, "overtemp");
    chk({15'h0000, fb_n}, 16'h0000, "fallback");
    chk({15'h0000, rst_wire}, 16'h0000, "reset pin low");
    oact = 1'b0;
    orel = 1'b1;
    pulse_len(n);
    orel = 1'b0;
    chk(16'(mode), 16'(SBCMC_STANDBY), "overtemp exit");
    chk({15'h0000, n > SHORT + 8}, 16'h0001, "long pulse");
    wr(ADDR_MODE_SELECT, 12'h000);
  endtask : t_otp
  task automatic t_poff();
    wr(ADDR_MODE_SELECT, 12'h800);
    wmode(SBCMC_NORMAL);
    poff = 1'b1;
    pon = 1'b0;
    wmode(SBCMC_OFF);
    outs(1'b0, 1'b1, WDT_OFF, LIN_HIGHZ, "off");
    poff = 1'b0;
    pon = 1'b1;
    wmode(SBCMC_STANDBY);
  endtask : t_poff
  initial begin
    {poff, oact, orel, wlin, wloc, wdis} = 6'h00;
    pon = 1'b1;
    ext_rst_n = 1'b1;
    reset_pin_n = 1'b0;
    repeat (16) @(posedge clk);
    #1 reset_pin_n = 1'b1;
    t_power_up();
    t_ro();
    t_normal();
    t_sleep();
    t_otp();
    t_poff();
    final_report();
  end
  initial begin
    #2_000_000;
    error_cnt++;
    final_report();
  end
endmodule : test_sbcmc_top
bind sbcmc_top sbcmc_properties #(
  .P_RST_SHORT_CYC(P_RST_SHORT_CYC), .P_RST_LONG_CYC(P_RST_LONG_CYC)
) u_props (
  .i_core_clk, .i_resetn, .i_chip_select_n, .i_bat_poff, .i_bat_pon, .i_otp_act, .o_spi_sdo_oe,
  .o_reset_pin_n_oe, .o_mcu_regulator_out, .o_lin_state, .o_wdt_state, .o_mode, .o_fallback_n);
`default_nettype wire
